//--- hw/msbp_consts.vh
`ifndef MSBP_CONSTS_VH
`define MSBP_CONSTS_VH
// register byte offsets on the bus
`define MSBP_ADDR_MODE 12'h000
`define MSBP_ADDR_CTRL 12'h004
`define MSBP_ADDR_STAT 12'h008
`define MSBP_ADDR_MASK 12'h00C
// mode register field positions
`define MSBP_BIT_START 0
`define MSBP_PAT_LO 1
`define MSBP_PAT_HI 3
`define MSBP_RSV_LO 4
`define MSBP_RSV_HI 5
`define MSBP_BIT_DIR 6
// control register field positions
`define MSBP_BIT_FILL_EN 0
// reset values
`define MSBP_MODE_RST 16'h0000
`define MSBP_CTRL_RST 16'h0000
`define MSBP_MASK_RST 2'h0
// status bits: fill done, fill aborted
`define MSBP_ST_DONE 0
`define MSBP_ST_ABORT 1
// connection memory size
`define MSBP_CM_WORDS 1024
`define MSBP_CM_AW 10
// frames taken by one fill
`define MSBP_FILL_FRAMES 2'h2
`endif

//--- hw/msbp_fill_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "msbp_consts.vh"
// block fill sequencer: walks connection memory over two frames
module msbp_fill_seq (
   input wire clk_i,
   input wire rst_i,
   input wire go_i,
   input wire abort_i,
   input wire frame_i,
   output wire busy_o,
   output reg done_o,
   output reg aborted_o,
   output wire wr_o,
   output wire [`MSBP_CM_AW-1:0] addr_o
);
   localparam ST_IDLE = 2'h0; // waiting for a start
   localparam ST_SYNC = 2'h1; // waiting for a frame boundary
   localparam ST_RUN = 2'h2; // filling during whole frames
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [1:0] frames_reg; // complete frames seen in run
   reg [1:0] frames_next;
   reg [`MSBP_CM_AW-1:0] addr_reg; // memory word pointer
   reg [`MSBP_CM_AW-1:0] addr_next;
   assign busy_o = (state_reg != ST_IDLE);
   assign wr_o = (state_reg == ST_RUN) && !abort_i;
   assign addr_o = addr_reg;
   // next state logic
   always @* begin
      state_next = state_reg;
      frames_next = frames_reg;
      addr_next = addr_reg;
      case (state_reg)
         ST_IDLE: begin
            frames_next = 2'h0;
            addr_next = {`MSBP_CM_AW{1'b0}};
            if (go_i) begin
               state_next = ST_SYNC;
            end
         end
         ST_SYNC: begin
            if (abort_i) begin
               state_next = ST_IDLE;
            end else if (frame_i) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            addr_next = addr_reg + {{(`MSBP_CM_AW-1){1'b0}}, 1'b1};
            if (abort_i) begin
               state_next = ST_IDLE;
            end else if (frame_i) begin
               frames_next = frames_reg + 2'h1;
               // R7: two complete frames end
               if (frames_reg + 2'h1 == `MSBP_FILL_FRAMES) begin
                  state_next = ST_IDLE;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end
   // state registers and one-cycle result pulses
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         frames_reg <= 2'h0;
         addr_reg <= {`MSBP_CM_AW{1'b0}};
         done_o <= 1'b0;
         aborted_o <= 1'b0;
      end else begin
         state_reg <= state_next;
         frames_reg <= frames_next;
         addr_reg <= addr_next;
         done_o <= (state_reg == ST_RUN) && !abort_i && (state_next == ST_IDLE);
         aborted_o <= (state_reg != ST_IDLE) && abort_i;
      end
   end
endmodule
`default_nettype wire

//--- hw/msbp_top.v
`timescale 1ns/1ps
`default_nettype none
`include "msbp_consts.vh"
// Operation
// R1: direction bit selects normal or bidirectional streams
// R2: host writes zero to bits 5-4
// R3: bits 3-1 hold the fill pattern
// R4: pattern copied into every memory low word
// R5: start bit rising edge begins the fill
// R6: host writes pattern with start bit
// R7: fill takes two complete frames
// R8: device clears start bit at completion
// R9: clearing start or enable aborts fill
// R10: host keeps other bits during fill
module msbp_top (
   input wire REF_CLK_I,
   input wire RST_I,
   input wire HSEL_I,
   input wire [31:0] HADDR_I,
   input wire [1:0] HTRANS_I,
   input wire HWRITE_I,
   input wire [2:0] HSIZE_I,
   input wire [31:0] HWDATA_I,
   input wire HREADY_I,
   output reg [31:0] HRDATA_O,
   output wire HREADYOUT_O,
   output wire HRESP_O,
   output wire IRQ_O,
   input wire FRAME_I,
   input wire [15:0] SERIAL_IN_LINES_I,
   output wire [15:0] SERIAL_IN_EFF_O,
   output wire [15:0] SERIAL_OUT_OE_O,
   output wire BIDIR_MODE_O,
   input wire [`MSBP_CM_AW-1:0] CM_RD_ADDR_I,
   output reg [2:0] CM_RD_DATA_O
);
   reg [15:0] mode_reg; // internal_mode_select register
   reg [15:0] mode_next; // mode register after this edge
   reg [15:0] ctrl_reg; // control register with block_fill_enable
   reg [15:0] ctrl_next; // control register after this edge
   reg [1:0] stat_reg; // sticky event bits
   reg [1:0] mask_reg; // interrupt mask
   reg [1:0] mask_next; // mask after this edge
   reg [2:0] cm_low_mem [0:`MSBP_CM_WORDS-1]; // connection memory low bits 2-0
   reg dp_wr_reg; // write data phase pending
   reg dp_rd_reg; // read data phase pending
   reg [11:0] dp_addr_reg; // latched address
   reg [1:0] rd_seen_reg; // status bits handed out by the last read
   reg [31:0] rdata_next; // read word chosen in the address phase
   reg start_q_reg; // start bit last cycle

   wire addr_ok; // address phase accepted this cycle
   wire addr_rd; // accepted phase is a read
   wire [11:0] addr_word; // word aligned address of the phase
   wire wr_mode; // data phase writes the mode register
   wire wr_ctrl; // data phase writes the control register
   wire wr_mask; // data phase writes the mask register
   wire rd_stat; // data phase reads the status register
   wire fill_en; // block_fill_enable bit
   wire start_bit; // start bit of the mode register
   wire start_rise; // start went high with enable set
   wire abort_req; // start or enable dropped
   wire seq_busy; // sequencer waiting or filling
   wire seq_done; // one cycle fill done pulse
   wire seq_aborted; // one cycle fill aborted pulse
   wire seq_wr; // memory write strobe
   wire [`MSBP_CM_AW-1:0] seq_addr; // memory word being filled
   wire [1:0] stat_kept; // sticky bits left after a read clear
   wire [1:0] stat_next; // sticky bits after this edge

   // ahb slave: zero wait, always okay
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;
   // address phase qualifiers
   assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];
   assign addr_rd = addr_ok && !HWRITE_I;
   assign addr_word = {HADDR_I[11:2], 2'h0};
   // data phase decodes
   assign wr_mode = dp_wr_reg && (dp_addr_reg == `MSBP_ADDR_MODE);
   assign wr_ctrl = dp_wr_reg && (dp_addr_reg == `MSBP_ADDR_CTRL);
   assign wr_mask = dp_wr_reg && (dp_addr_reg == `MSBP_ADDR_MASK);
   assign rd_stat = dp_rd_reg && (dp_addr_reg == `MSBP_ADDR_STAT);

   // fields that steer the fill
   assign fill_en = ctrl_reg[`MSBP_BIT_FILL_EN];
   assign start_bit = mode_reg[`MSBP_BIT_START];

   // R5: rising start edge
   assign start_rise = start_bit && !start_q_reg && fill_en;
   // R9: abort on start or enable low
   assign abort_req = !start_bit || !fill_en;

   // R1: bidirectional mode forces inputs low
   assign BIDIR_MODE_O = mode_reg[`MSBP_BIT_DIR];
   assign SERIAL_IN_EFF_O = BIDIR_MODE_O ? 16'h0000 : SERIAL_IN_LINES_I;
   // output drivers off while the pins run both ways
   assign SERIAL_OUT_OE_O = BIDIR_MODE_O ? 16'h0000 : 16'hFFFF;
   // interrupt: unmasked sticky bits
   assign IRQ_O = |(stat_reg & mask_reg);
   // a read clears only the bits it reported
   assign stat_kept = stat_reg & ~(rd_stat ? rd_seen_reg : 2'h0);
   // new events set their bits, set beats the clear
   assign stat_next = stat_kept | {seq_aborted, seq_done};

   // R7: fill sequencer, two frame fill
   msbp_fill_seq u_seq (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .go_i(start_rise),
      .abort_i(abort_req),
      .frame_i(FRAME_I),
      .busy_o(seq_busy),
      .done_o(seq_done),
      .aborted_o(seq_aborted),
      .wr_o(seq_wr),
      .addr_o(seq_addr)
   );

   // address phase capture and registered read data
   always @(posedge REF_CLK_I) begin
      if (RST_I) begin
         // idle bus after reset
         dp_wr_reg <= 1'b0;
         dp_rd_reg <= 1'b0;
         dp_addr_reg <= 12'h000;
         rd_seen_reg <= 2'h0;
         HRDATA_O <= 32'h00000000;
      end else begin
         // data phase follows every accepted address phase
         dp_wr_reg <= addr_ok && HWRITE_I;
         dp_rd_reg <= addr_rd;
         if (addr_ok) begin
            dp_addr_reg <= addr_word;
         end
         // read word and reported status held for the data phase
         if (addr_rd) begin
            HRDATA_O <= rdata_next;
            rd_seen_reg <= stat_kept;
         end
      end
   end

   // read data mux, mode, control and mask from values after this edge, unmapped reads zero
   always @* begin
      // status shows busy and the bits that survive a read clear
      case (addr_word)
         `MSBP_ADDR_MODE: begin
            rdata_next = {16'h0000, mode_next};
         end
         `MSBP_ADDR_CTRL: begin
            rdata_next = {16'h0000, ctrl_next};
         end
         `MSBP_ADDR_STAT: begin
            rdata_next = {29'h00000000, seq_busy, stat_kept};
         end
         `MSBP_ADDR_MASK: begin
            rdata_next = {30'h00000000, mask_next};
         end
         default: rdata_next = 32'h00000000;
      endcase
   end

   // next register values from the data phase write
   always @* begin
      // defaults hold every register
      mode_next = mode_reg;
      ctrl_next = ctrl_reg;
      mask_next = mask_reg;
      // R3: pattern, direction and start written together
      if (wr_mode) begin
         mode_next = {9'h000, HWDATA_I[6:0]};
      end
      // R8: start bit cleared on completion, even against a write
      if (seq_done) begin
         mode_next[`MSBP_BIT_START] = 1'b0;
      end
      // block_fill_enable and the rest of control
      if (wr_ctrl) begin
         ctrl_next = HWDATA_I[15:0];
      end
      // interrupt mask bits
      if (wr_mask) begin
         mask_next = HWDATA_I[1:0];
      end
   end

   // register updates and start edge history
   always @(posedge REF_CLK_I) begin
      if (RST_I) begin
         // all control state to reset values
         mode_reg <= `MSBP_MODE_RST;
         ctrl_reg <= `MSBP_CTRL_RST;
         mask_reg <= `MSBP_MASK_RST;
         stat_reg <= 2'h0;
         start_q_reg <= 1'b0;
      end else begin
         // every register loads its next value
         start_q_reg <= start_bit;
         stat_reg <= stat_next;
         mode_reg <= mode_next;
         ctrl_reg <= ctrl_next;
         mask_reg <= mask_next;
      end
   end

   // R4: write pattern into memory low word
   // no reset: contents are defined only once a fill ran
   always @(posedge REF_CLK_I) begin
      if (seq_wr) begin
         cm_low_mem[seq_addr] <= mode_reg[`MSBP_PAT_HI:`MSBP_PAT_LO];
      end
   end

   // memory read port for the switch core
   always @(posedge REF_CLK_I) begin
      if (RST_I) begin
         // only the read register, the memory itself keeps its words
         CM_RD_DATA_O <= 3'h0;
      end else begin
         CM_RD_DATA_O <= cm_low_mem[CM_RD_ADDR_I];
      end
   end
endmodule
`default_nettype wire

//--- bench/msbp_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "msbp_consts.vh"
// bus and mode pin checks on the top ports
module msbp_checker (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   input wire logic IRQ_O,
   input wire logic [15:0] SERIAL_IN_LINES_I,
   input wire logic [15:0] SERIAL_IN_EFF_O,
   input wire logic [15:0] SERIAL_OUT_OE_O,
   input wire logic BIDIR_MODE_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   logic take; // address phase accepted
   logic wm_q; // data phase of a mode write
   logic ru_q; // data phase of an unmapped read
   assign take = HSEL_I && HREADY_I && HTRANS_I[1];
   // follow accepted address phases
   always @(posedge REF_CLK_I) begin
      wm_q <= !RST_I && take && HWRITE_I && HADDR_I[11:0] == `MSBP_ADDR_MODE;
      ru_q <= !RST_I && take && !HWRITE_I && HADDR_I[11:0] > `MSBP_ADDR_MASK;
   end
   zero_wait_a: assert property (HREADYOUT_O && !HRESP_O)
      else $error("wait or error answer");
   dir_write_a: assert property (wm_q |=> BIDIR_MODE_O == $past(HWDATA_I[6]))
      else $error("direction bit not stored");
   dir_hold_a: assert property (!wm_q |=> $stable(BIDIR_MODE_O))
      else $error("direction bit moved");
   bidir_in_a: assert property (BIDIR_MODE_O |-> SERIAL_IN_EFF_O == 16'h0000)
      else $error("inputs not forced low");
   norm_in_a: assert property (!BIDIR_MODE_O |-> SERIAL_IN_EFF_O == SERIAL_IN_LINES_I)
      else $error("inputs not passed");
   out_en_a: assert property (SERIAL_OUT_OE_O == {16{!BIDIR_MODE_O}})
      else $error("output enable wrong");
   unmapped_rd_a: assert property (ru_q |-> HRDATA_O == 32'h0)
      else $error("unmapped read not zero");
   reset_val_a: assert property ($fell(RST_I) |-> !IRQ_O && !BIDIR_MODE_O)
      else $error("bad value after reset");
   cover property ($rose(IRQ_O));
   cover property ($rose(BIDIR_MODE_O));
   cover property (ru_q);
endmodule
bind msbp_top msbp_checker u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I),
   .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I),
   .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
   .IRQ_O(IRQ_O), .SERIAL_IN_LINES_I(SERIAL_IN_LINES_I), .SERIAL_IN_EFF_O(SERIAL_IN_EFF_O),
   .SERIAL_OUT_OE_O(SERIAL_OUT_OE_O), .BIDIR_MODE_O(BIDIR_MODE_O));
`default_nettype wire

//--- bench/msbp_frame_src.sv
`timescale 1ns/1ps
`default_nettype none
// frame source: one-cycle frame pulse, lines rotated and inverted every cycle
module msbp_frame_src #(
   parameter int PERIOD = 1100
) (
   input wire logic clk_i,
   input wire logic rst_i,
   output var logic frame_o,
   output var logic [15:0] lines_o
);
   int cnt = 0; // cycles into the frame
   // frame counter and line pattern
   always @(posedge clk_i) begin
      cnt <= (rst_i || cnt == PERIOD - 1) ? 0 : cnt + 1;
      frame_o <= !rst_i && cnt == PERIOD - 1;
      lines_o <= rst_i ? 16'hA5C3 : ~{lines_o[14:0], lines_o[15]};
   end
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "msbp_consts.vh"
// register, direction and block fill tests
module testbench;
   localparam int PER = 1100; // frame length in clocks
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, irq, frame, hready, bidir;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [9:0] cm_a = 10'h000;
   logic [2:0] cm_d;
   logic [15:0] lines, eff, oe;
   int n_mismatch = 0, check_count = 0;
   time t0;
   msbp_frame_src #(.PERIOD(PER)) u_src (.clk_i(clk), .rst_i(rst), .frame_o(frame),
      .lines_o(lines));
   msbp_top u_dut (.REF_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .IRQ_O(irq),
      .FRAME_I(frame), .SERIAL_IN_LINES_I(lines), .SERIAL_IN_EFF_O(eff),
      .SERIAL_OUT_OE_O(oe), .BIDIR_MODE_O(bidir), .CM_RD_ADDR_I(cm_a), .CM_RD_DATA_O(cm_d));
   initial forever #20 clk = ~clk;
   // single word transfer held until hready
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", s, e, g);
      end
   endtask
   task automatic cm(input logic [9:0] a, input logic [2:0] e);
      @(posedge clk);
      cm_a <= a;
      repeat (2) @(posedge clk);
      chk("cm_word", {29'h0, e}, {29'h0, cm_d});
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // reset value, unmapped read, both directions
   task automatic t_regs;
      bus(1'b0, 12'h040, 32'h0);
      bus(1'b0, `MSBP_ADDR_MODE, 32'h0);
      chk("mode", 32'h0, q);
      bus(1'b1, `MSBP_ADDR_MODE, 32'h40);
      @(negedge clk);
      chk("in_eff", 32'h0, {16'h0, eff});
      chk("out_oe_bidir", 32'h0, {16'h0, oe});
      chk("bidir", 32'h1, {31'h0, bidir});
      bus(1'b1, `MSBP_ADDR_MODE, 32'h0);
      @(negedge clk);
      chk("out_oe", 32'hFFFF, {16'h0, oe});
      chk("in_eff_norm", {16'h0, lines}, {16'h0, eff});
      $display("test regs done");
   endtask
   // full fill with pattern 5, completion seen by polling
   task automatic t_fill;
      int n = 0;
      bus(1'b1, `MSBP_ADDR_MASK, 32'h3);
      bus(1'b1, `MSBP_ADDR_CTRL, 32'h1);
      bus(1'b1, `MSBP_ADDR_MODE, 32'hB);
      t0 = $time;
      do begin bus(1'b0, `MSBP_ADDR_MODE, 32'h0); n++; end while (q[0] === 1'b1 && n < 3000);
      chk("fill_time", 32'h1, {31'h0, (($time - t0) / 40) >= 2 * PER});
      chk("mode_done", 32'hA, q);
      chk("irq", 32'h1, {31'h0, irq});
      bus(1'b0, `MSBP_ADDR_STAT, 32'h0);
      chk("status", 32'h1, q);
      for (int a = 0; a < 1024; a += 511) cm(a[9:0], 3'h5);
      $display("test fill done");
   endtask
   // abort soon after writing starts, by start (0) or enable (1)
   task automatic t_abort(input int way);
      bus(1'b1, `MSBP_ADDR_CTRL, 32'h1);
      bus(1'b1, `MSBP_ADDR_MODE, 32'h5);
      @(posedge clk);
      @(posedge frame);
      repeat (8) @(posedge clk);
      if (way == 0) bus(1'b1, `MSBP_ADDR_MODE, 32'h4);
      else bus(1'b1, `MSBP_ADDR_CTRL, 32'h0);
      repeat (2 * PER) @(posedge clk);
      bus(1'b0, `MSBP_ADDR_STAT, 32'h0);
      chk("abort_status", 32'h2, q);
      cm(10'h258, 3'h5);
      cm(10'h000, 3'h2);
      $display("test abort %0d done", way);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_fill;
      for (int w = 0; w < 2; w++) t_abort(w);
      complete_run;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      complete_run;
   end
endmodule
`default_nettype wire
